/* verilog/mchi_pkg.sv */
// Shared constants and types of the motion controller host port.
package mchi_pkg;

  // Low address field of the parallel map, one byte per address.
  localparam logic [1:0] LA_CMD = 2'h0;
  localparam logic [1:0] LA_LOW = 2'h1;
  localparam logic [1:0] LA_MID = 2'h2;
  localparam logic [1:0] LA_UP = 2'h3;

  // Axis codes carried on the upper address pair.
  localparam logic [1:0] AX_X = 2'h0;
  localparam logic [1:0] AX_Y = 2'h1;
  localparam logic [1:0] AX_Z = 2'h2;
  localparam logic [1:0] AX_U = 2'h3;

  // Reference clock cycles of internal processing after a command or register commit.
  localparam logic [1:0] PROC_CYCLES = 2'h3;

  // Serial frame layout: byte 0 carries device number and axis, byte 1 the command.
  localparam int FR_DEV_LSB = 0;
  localparam int FR_AXIS_LSB = 2;
  localparam logic [2:0] FR_CMD_BYTES = 3'h2;
  localparam logic [2:0] FR_REG_BYTES = 3'h5;
  localparam logic [2:0] FR_MAX_BYTES = 3'h5;

  // Synchronised pin bundle width: select, write, read, four address, eight data.
  localparam int PIN_SYNC_W = 15;
  localparam int SP_PINS = 6;

  // Processing state of the command path.
  typedef enum logic {MCHI_IDLE, MCHI_BUSY} mchi_proc_t;

endpackage : mchi_pkg

/* verilog/mchi_link_if.sv */
// Signals passed between the reference clock logic and the serial front end.
`timescale 1ns/1ps
interface mchi_link_if #(parameter int NUM_AXES = 4);
  logic ss_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic [1:0] unit_id;
  logic serial_mode;
  logic [2:0] nbytes;
  logic [39:0] frame;
  logic [NUM_AXES*24-1:0] snapshot;

  // The front end sees pins and quasi-static values, and returns its frame.
  modport link (input ss_n, input mosi, input unit_id, input serial_mode, input snapshot,
                output miso, output miso_oe_n, output nbytes, output frame);
  modport core (output ss_n, output mosi, output unit_id, output serial_mode, output snapshot,
                input miso, input miso_oe_n, input nbytes, input frame);
endinterface : mchi_link_if

/* verilog/mchi_sync.sv */
// Two flip-flop synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
module mchi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  // No reset here, so that levels present during reset reach the sampling logic.
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out <= meta_q;
  end
endmodule : mchi_sync

/* verilog/mchi_spi_link.sv */
// Serial front end clocked by the host serial clock, mode 0 or mode 3 framing.
`timescale 1ns/1ps
module mchi_spi_link import mchi_pkg::*; #(
  parameter int NUM_AXES = 4
) (
  input wire logic spi_sck_in,
  mchi_link_if.link lk
);
  logic active_q, active_d;
  logic [2:0] bitcnt_q, bitcnt_d;
  logic [2:0] nbytes_q, nbytes_d;
  logic [6:0] shift_q, shift_d;
  logic [39:0] frame_q, frame_d;
  logic miso_q, miso_d;
  logic miso_oe_n_q, miso_oe_n_d;
  logic [2:0] stat_s;
  logic match;
  logic [7:0] tx_byte;
  logic [1:0] tx_axis;

  // Strap and mode are static, but still pass two serial clock flops before use.
  mchi_sync #(.WIDTH(3)) u_sync (
    .clk_in(spi_sck_in),
    .d_in({lk.serial_mode, lk.unit_id}),
    .q_out(stat_s)
  );

  // Byte capture: sample on rising serial clock, byte counter saturates at the frame length.
  always_comb begin
    active_d = 1'b1;
    shift_d = {shift_q[5:0], lk.mosi};
    frame_d = frame_q;
    if (!active_q) begin
      bitcnt_d = 3'h1;
      nbytes_d = 3'h0;
      shift_d = {6'h00, lk.mosi};
    end else begin
      bitcnt_d = bitcnt_q + 3'h1;
      nbytes_d = nbytes_q;
      if (bitcnt_q == 3'h7) begin
        if (nbytes_q < FR_MAX_BYTES) begin
          frame_d[nbytes_q*8 +: 8] = {shift_q, lk.mosi};
          nbytes_d = nbytes_q + 3'h1;
        end
      end
    end
  end

  // The active flag is cleared by slave select, so counters restart on a new frame only.
  always_ff @(posedge spi_sck_in or posedge lk.ss_n) begin
    if (lk.ss_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  // Frame registers hold their content after the frame so the reference side can read them.
  always_ff @(posedge spi_sck_in) begin
    bitcnt_q <= bitcnt_d;
    nbytes_q <= nbytes_d;
    shift_q <= shift_d;
    frame_q <= frame_d;
  end

  // Only the device whose strap matches the frame's device number answers.
  assign match = (nbytes_q != 3'h0) && (frame_q[FR_DEV_LSB +: 2] == stat_s[1:0]);
  assign tx_axis = frame_q[FR_AXIS_LSB +: 2];
  assign tx_byte = (nbytes_q >= FR_CMD_BYTES && nbytes_q < FR_REG_BYTES && int'(tx_axis) < NUM_AXES) ?
                   lk.snapshot[int'(tx_axis)*24 + int'(nbytes_q - FR_CMD_BYTES)*8 +: 8] : 8'h00;

  // Data out changes on the falling edge, ahead of the host's rising sample edge.
  always_comb begin
    miso_d = tx_byte[3'h7 - bitcnt_q];
    miso_oe_n_d = !(active_q && stat_s[2] && match && nbytes_q >= FR_CMD_BYTES && nbytes_q < FR_REG_BYTES);
  end

  // Slave select high releases the line at once, without waiting for a clock edge.
  always_ff @(negedge spi_sck_in or posedge lk.ss_n) begin
    if (lk.ss_n) begin
      miso_q <= 1'b1;
      miso_oe_n_q <= 1'b1;
    end else begin
      miso_q <= miso_d;
      miso_oe_n_q <= miso_oe_n_d;
    end
  end

  assign lk.miso = miso_q;
  assign lk.miso_oe_n = miso_oe_n_q;
  assign lk.nbytes = nbytes_q;
  assign lk.frame = frame_q;

  // A foreign device number must keep the data line released.
  property p_nomatch_hiz;
    @(negedge spi_sck_in) disable iff (lk.ss_n)
    (active_q && !match) |=> miso_oe_n_q;
  endproperty
  a_nomatch_hiz: assert property (p_nomatch_hiz) else $error("Data line driven for another device.");

  // Each completed byte up to the fifth advances the byte count by one.
  property p_byte_count;
    @(posedge spi_sck_in) disable iff (lk.ss_n)
    (active_q && bitcnt_q == 3'h7 && nbytes_q < FR_MAX_BYTES) |=> nbytes_q == $past(nbytes_q) + 3'h1;
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("Serial byte count did not advance.");
endmodule : mchi_spi_link

/* verilog/mchi_host_port.sv */
// Host port: parallel bus slave, serial front end selection, and command/register buffers.
// How it works
// - Strobes sampled during reset choose interface.
// - Serial link uses mode 0 or 3.
// - Respond only to matching strapped unit id.
// - Serial front end on serial clock.
// - Serial mode: low six data pins shared.
// - Interrupt output same in both modes.
// - Four byte addresses per axis, low pair.
// - Write low 00b loads command buffer.
// - Read low 00b returns main status.
// - Writes 01b..11b load write buffer bytes.
// - Low byte write commits all 24 bits.
// - Reads 01b..11b return read buffer bytes.
// - Read buffer copies selected register value.
// - Four axes: upper pair picks axis.
// - Two axes: one select bit, eight addresses.
// - One axis: four addresses, no select.
// - Access during processing pulls hold low.
`timescale 1ns/1ps
module mchi_host_port import mchi_pkg::*; #(
  parameter int NUM_AXES = 4
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic spi_sck_in,
  input wire logic cs_ss_n_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  input wire logic [3:0] addr_lines_in,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic [7:0] host_data_bus_oe_n_out,
  output logic hold_request_n_out,
  output logic miso_out,
  output logic miso_oe_n_out,
  output logic int_n_out,
  output logic serial_mode_out,
  input wire logic irq_n_in,
  input wire logic [NUM_AXES*8-1:0] main_status_in,
  input wire logic [NUM_AXES*24-1:0] reg_read_data_in,
  input wire logic [SP_PINS-1:0] sp_value_in,
  input wire logic [SP_PINS-1:0] sp_drive_in,
  output logic [SP_PINS-1:0] shared_port_pins_out,
  output logic cmd_valid_out,
  output logic [1:0] cmd_axis_out,
  output logic [7:0] cmd_byte_out,
  output logic regw_valid_out,
  output logic [1:0] regw_axis_out,
  output logic [23:0] regw_data_out
);
  mchi_link_if #(.NUM_AXES(NUM_AXES)) lk ();

  logic [PIN_SYNC_W-1:0] pins_s;
  logic cs_s, wr_s, rd_s, ss_q3;
  logic [3:0] addr_s;
  logic [7:0] data_s;
  logic cs_q3, cs_q3_d, wr_q3, wr_q3_d, ss_q3_d;
  logic [3:0] addr_q3, addr_q3_d;
  logic [7:0] data_q3, data_q3_d;
  logic serial_mode_q, serial_mode_d;
  logic [1:0] uid_q, uid_d;
  logic [NUM_AXES*24-1:0] wbuf_q, wbuf_d;
  logic [NUM_AXES*24-1:0] rdbuf_q, rdbuf_d;
  mchi_proc_t proc_q, proc_d;
  logic [1:0] pcnt_q, pcnt_d;
  logic cmd_valid_q, cmd_valid_d, regw_valid_q, regw_valid_d;
  logic [1:0] cmd_axis_q, cmd_axis_d, regw_axis_q, regw_axis_d;
  logic [7:0] cmd_byte_q, cmd_byte_d;
  logic [23:0] regw_data_q, regw_data_d;
  logic spend_q, spend_d;
  logic [1:0] spend_axis_q, spend_axis_d;
  logic [23:0] spend_data_q, spend_data_d;
  logic hold_n_q, hold_n_d, int_n_q, int_n_d;
  logic [7:0] dout_q, dout_d, doe_n_q, doe_n_d;
  logic [SP_PINS-1:0] sp_q, sp_d;
  logic par_wr, par_rd, par_access, commit, ser_end, ser_match;
  logic [1:0] wr_axis, rd_axis, ser_axis;

  // Axis from the upper address pair, by device width; missing select pins read as axis X.
  function automatic logic [1:0] axis_of(input logic [3:0] a);
    if (NUM_AXES == 4) begin
      axis_of = a[3:2];
    end else if (NUM_AXES == 2) begin
      axis_of = {1'b0, a[2]};
    end else begin
      axis_of = AX_X;
    end
  endfunction : axis_of

  // Read side of the per-axis map: status at the command address, read buffer bytes above.
  function automatic logic [7:0] read_byte(input logic [1:0] ax, input logic [1:0] la,
                                           input logic [NUM_AXES*8-1:0] sts,
                                           input logic [NUM_AXES*24-1:0] rb);
    case (la)
      LA_CMD: read_byte = sts[int'(ax)*8 +: 8];
      LA_LOW: read_byte = rb[int'(ax)*24 +: 8];
      LA_MID: read_byte = rb[int'(ax)*24 + 8 +: 8];
      LA_UP: read_byte = rb[int'(ax)*24 + 16 +: 8];
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // Every pin is synchronised before reference clock logic reads it; the serial front end reads select and data unsynchronised.
  mchi_sync #(.WIDTH(PIN_SYNC_W)) u_pin_sync (
    .clk_in(sys_clk_in),
    .d_in({cs_ss_n_in, wr_n_in, rd_n_in, addr_lines_in, host_data_bus_in}),
    .q_out(pins_s)
  );
  assign {cs_s, wr_s, rd_s, addr_s, data_s} = pins_s;

  // The serial front end runs entirely on the host's serial clock.
  mchi_spi_link #(.NUM_AXES(NUM_AXES)) u_link (
    .spi_sck_in(spi_sck_in),
    .lk(lk.link)
  );
  assign lk.ss_n = cs_ss_n_in;
  assign lk.mosi = host_data_bus_in[7];
  assign lk.unit_id = addr_lines_in[1:0];
  assign lk.serial_mode = serial_mode_q;
  assign lk.snapshot = rdbuf_q;

  // Strobe decode: the write is taken on the trailing edge of the write strobe under select.
  assign par_wr = !serial_mode_q && wr_s && !wr_q3 && !cs_q3;
  assign par_rd = !serial_mode_q && !cs_s && !rd_s;
  assign par_access = !serial_mode_q && !cs_s && (!wr_s || !rd_s);
  assign wr_axis = axis_of(addr_q3);
  assign rd_axis = axis_of(addr_s);
  // Serial frames end on the synchronised rising edge of slave select; link registers are idle then.
  assign ser_end = serial_mode_q && ss_q3 == 1'b0 && cs_s && lk.nbytes >= FR_CMD_BYTES;
  assign ser_match = lk.frame[FR_DEV_LSB +: 2] == uid_q;
  assign ser_axis = lk.frame[FR_AXIS_LSB +: 2];
  assign commit = cmd_valid_d || regw_valid_d;

  // Mode and strap capture: while reset is high the synchronised strobes are sampled each edge.
  always_comb begin
    serial_mode_d = serial_mode_q;
    uid_d = uid_q;
    if (srst_in) begin
      serial_mode_d = !wr_s && !rd_s;
      uid_d = addr_s[1:0];
    end
    cs_q3_d = cs_s;
    wr_q3_d = wr_s;
    ss_q3_d = cs_s;
    addr_q3_d = addr_s;
    data_q3_d = data_s;
  end

  // Write path: command buffer, write buffer bytes, and the commit on the low byte.
  always_comb begin
    wbuf_d = wbuf_q;
    cmd_valid_d = 1'b0;
    cmd_axis_d = cmd_axis_q;
    cmd_byte_d = cmd_byte_q;
    regw_valid_d = 1'b0;
    regw_axis_d = regw_axis_q;
    regw_data_d = regw_data_q;
    spend_d = spend_q;
    spend_axis_d = spend_axis_q;
    spend_data_d = spend_data_q;
    if (par_wr && int'(wr_axis) < NUM_AXES) begin
      case (addr_q3[1:0])
        LA_CMD: begin
          cmd_valid_d = 1'b1;
          cmd_axis_d = wr_axis;
          cmd_byte_d = data_q3;
        end
        LA_LOW: begin
          wbuf_d[int'(wr_axis)*24 +: 8] = data_q3;
          regw_valid_d = 1'b1;
          regw_axis_d = wr_axis;
          regw_data_d = {wbuf_q[int'(wr_axis)*24 + 8 +: 16], data_q3};
        end
        LA_MID: wbuf_d[int'(wr_axis)*24 + 8 +: 8] = data_q3;
        LA_UP: wbuf_d[int'(wr_axis)*24 + 16 +: 8] = data_q3;
        default: wbuf_d = wbuf_q;
      endcase
    end else if (spend_q) begin
      // A serial register write follows its command by one cycle.
      spend_d = 1'b0;
      regw_valid_d = 1'b1;
      regw_axis_d = spend_axis_q;
      regw_data_d = spend_data_q;
    end else if (ser_end && ser_match && int'(ser_axis) < NUM_AXES) begin
      cmd_valid_d = 1'b1;
      cmd_axis_d = ser_axis;
      cmd_byte_d = lk.frame[15:8];
      spend_d = lk.nbytes == FR_REG_BYTES;
      spend_axis_d = ser_axis;
      spend_data_d = lk.frame[39:16];
    end
  end

  // Processing timer and hold request: an access arriving while busy is held off.
  always_comb begin
    proc_d = proc_q;
    pcnt_d = pcnt_q;
    case (proc_q)
      MCHI_IDLE: begin
        if (commit) begin
          proc_d = MCHI_BUSY;
          pcnt_d = PROC_CYCLES - 2'h1;
        end
      end
      MCHI_BUSY: begin
        if (commit) begin
          pcnt_d = PROC_CYCLES - 2'h1;
        end else if (pcnt_q == 2'h0) begin
          proc_d = MCHI_IDLE;
        end else begin
          pcnt_d = pcnt_q - 2'h1;
        end
      end
      default: proc_d = MCHI_IDLE;
    endcase
    hold_n_d = !(proc_q == MCHI_BUSY && par_access);
    int_n_d = irq_n_in;
  end

  // Bus drive: read data in parallel mode, shared ports on the low six lines in serial mode.
  always_comb begin
    dout_d = 8'h00;
    doe_n_d = 8'hFF;
    sp_d = sp_q;
    // Read buffer follows the core, but is frozen during a serial frame for the front end.
    rdbuf_d = (serial_mode_q && !cs_s) ? rdbuf_q : reg_read_data_in;
    if (serial_mode_q) begin
      dout_d = {2'h0, sp_value_in};
      doe_n_d = {2'h3, ~sp_drive_in};
      sp_d = data_s[SP_PINS-1:0];
    end else if (par_rd && int'(rd_axis) < NUM_AXES) begin
      dout_d = read_byte(rd_axis, addr_s[1:0], main_status_in, rdbuf_q);
      doe_n_d = 8'h00;
    end
  end

  // State registers; the synchronous reset returns all control state to idle.
  always_ff @(posedge sys_clk_in) begin
    serial_mode_q <= serial_mode_d;
    uid_q <= uid_d;
    cs_q3 <= cs_q3_d;
    wr_q3 <= wr_q3_d;
    ss_q3 <= ss_q3_d;
    addr_q3 <= addr_q3_d;
    data_q3 <= data_q3_d;
    if (srst_in) begin
      wbuf_q <= '0;
      rdbuf_q <= '0;
      proc_q <= MCHI_IDLE;
      pcnt_q <= 2'h0;
      cmd_valid_q <= 1'b0;
      cmd_axis_q <= 2'h0;
      cmd_byte_q <= 8'h00;
      regw_valid_q <= 1'b0;
      regw_axis_q <= 2'h0;
      regw_data_q <= 24'h000000;
      spend_q <= 1'b0;
      spend_axis_q <= 2'h0;
      spend_data_q <= 24'h000000;
      hold_n_q <= 1'b1;
      int_n_q <= 1'b1;
      dout_q <= 8'h00;
      doe_n_q <= 8'hFF;
      sp_q <= '0;
    end else begin
      wbuf_q <= wbuf_d;
      rdbuf_q <= rdbuf_d;
      proc_q <= proc_d;
      pcnt_q <= pcnt_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_axis_q <= cmd_axis_d;
      cmd_byte_q <= cmd_byte_d;
      regw_valid_q <= regw_valid_d;
      regw_axis_q <= regw_axis_d;
      regw_data_q <= regw_data_d;
      spend_q <= spend_d;
      spend_axis_q <= spend_axis_d;
      spend_data_q <= spend_data_d;
      hold_n_q <= hold_n_d;
      int_n_q <= int_n_d;
      dout_q <= dout_d;
      doe_n_q <= doe_n_d;
      sp_q <= sp_d;
    end
  end

  assign host_data_bus_out = dout_q;
  assign host_data_bus_oe_n_out = doe_n_q;
  assign hold_request_n_out = hold_n_q;
  assign miso_out = lk.miso;
  assign miso_oe_n_out = lk.miso_oe_n;
  assign int_n_out = int_n_q;
  assign serial_mode_out = serial_mode_q;
  assign shared_port_pins_out = sp_q;
  assign cmd_valid_out = cmd_valid_q;
  assign cmd_axis_out = cmd_axis_q;
  assign cmd_byte_out = cmd_byte_q;
  assign regw_valid_out = regw_valid_q;
  assign regw_axis_out = regw_axis_q;
  assign regw_data_out = regw_data_q;

  // Mode follows the strobes seen during reset, even on the release edge.
  // Three reset edges come first, so that the unreset synchroniser has filled with pin levels.
  property p_mode_latch;
    @(posedge sys_clk_in) srst_in[*3] |=> serial_mode_q == $past(!wr_s && !rd_s);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("Interface mode not taken from strobes.");

  property p_cmd_write;
    @(posedge sys_clk_in) disable iff (srst_in)
    (par_wr && addr_q3[1:0] == LA_CMD && int'(wr_axis) < NUM_AXES) |=> cmd_valid_q && cmd_byte_q == $past(data_q3);
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("Command byte not loaded.");

  property p_low_commit;
    @(posedge sys_clk_in) disable iff (srst_in)
    (par_wr && addr_q3[1:0] == LA_LOW && int'(wr_axis) < NUM_AXES) |=> regw_valid_q && regw_data_q[7:0] == $past(data_q3);
  endproperty
  a_low_commit: assert property (p_low_commit) else $error("Low byte write did not commit.");

  property p_upper_store;
    @(posedge sys_clk_in) disable iff (srst_in)
    (par_wr && addr_q3[1:0] != LA_LOW && addr_q3[1:0] != LA_CMD) |=> !regw_valid_q;
  endproperty
  a_upper_store: assert property (p_upper_store) else $error("Middle or upper byte caused a commit.");

  property p_status_read;
    @(posedge sys_clk_in) disable iff (srst_in)
    (par_rd && addr_s[1:0] == LA_CMD && int'(rd_axis) < NUM_AXES) |=>
      doe_n_q == 8'h00 && dout_q == $past(main_status_in[int'(rd_axis)*8 +: 8]);
  endproperty
  a_status_read: assert property (p_status_read) else $error("Main status not returned.");

  property p_busy_time;
    @(posedge sys_clk_in) disable iff (srst_in)
    (commit && proc_q == MCHI_IDLE) ##1 !commit[*3] |-> ##1 proc_q == MCHI_IDLE;
  endproperty
  a_busy_time: assert property (p_busy_time) else $error("Processing time is not three cycles.");

  property p_hold;
    @(posedge sys_clk_in) disable iff (srst_in)
    (proc_q == MCHI_BUSY && par_access) |=> !hold_request_n_out;
  endproperty
  a_hold: assert property (p_hold) else $error("Hold request not raised while busy.");

  property p_int_follow;
    @(posedge sys_clk_in) disable iff (srst_in)
    ##1 int_n_out == $past(irq_n_in);
  endproperty
  a_int_follow: assert property (p_int_follow) else $error("Interrupt output not following source.");

  property p_shared_pins;
    @(posedge sys_clk_in) disable iff (srst_in)
    serial_mode_q ##1 serial_mode_q |-> doe_n_q[7:6] == 2'h3 && doe_n_q[5:0] == $past(~sp_drive_in);
  endproperty
  a_shared_pins: assert property (p_shared_pins) else $error("Shared port drive wrong in serial mode.");
endmodule : mchi_host_port

/* dv/mchi_host_model.sv */
// Behavioural host CPU that drives the parallel bus or the serial link of the host port.
`timescale 1ns/1ps
module mchi_host_model (
  input wire logic sys_clk_in,
  input wire logic miso_in,
  input wire logic [7:0] bus_in,
  output logic cs_n_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic sck_out,
  output logic [3:0] addr_out,
  output logic [7:0] data_out,
  output logic drive_out
);
  // Idle cycles after a write strobe; a host that ignores the wait request needs the full gap.
  int tail = 5;

  // Quiet bus at time zero, strobes high so the parallel interface is chosen by default.
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    sck_out = 1'b0;
    addr_out = 4'h0;
    data_out = 8'h00;
    drive_out = 1'b0;
  end

  // Mode straps; a serial host keeps both strobes low for good, as they have no other use.
  task straps(input logic serial);
    cs_n_out = 1'b1;
    wr_n_out = ~serial;
    rd_n_out = ~serial;
    addr_out = 4'h2;
    data_out = serial ? 8'h2A : 8'h00;
    drive_out = serial;
  endtask : straps

  // Write cycle; data is taken at the trailing edge of the strobe, so address and data outlive it.
  task pwr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    cs_n_out = 1'b0;
    addr_out = a;
    data_out = d;
    drive_out = 1'b1;
    wr_n_out = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    wr_n_out = 1'b1;
    repeat (tail) @(negedge sys_clk_in);
    drive_out = 1'b0;
  endtask : pwr

  // Read cycle; the gap afterwards lets the device's drive pipeline empty before the next cycle.
  task prd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    cs_n_out = 1'b0;
    addr_out = a;
    rd_n_out = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    d = bus_in;
    rd_n_out = 1'b1;
    cs_n_out = 1'b1;
    repeat (5) @(negedge sys_clk_in);
  endtask : prd

  // Mode 0 frame at an 80 ns clock period, which stays within twice the reference and 15 MHz.
  task sframe(input int n, input logic [39:0] tx, output logic [39:0] rx);
    @(negedge sys_clk_in);
    #13;
    cs_n_out = 1'b0;
    rx = '0;
    for (int i = 0; i < n * 8; i++) begin
      data_out[7] = tx[39 - i];
      #40;
      sck_out = 1'b1;
      data_out[6] = 1'b1;
      rx = {rx[38:0], miso_in};
      #40;
      sck_out = 1'b0;
      data_out[6] = 1'b0;
    end
    #40;
    cs_n_out = 1'b1;
    repeat (8) @(negedge sys_clk_in);
  endtask : sframe
endmodule : mchi_host_model

/* dv/mchi_host_port_bench.sv */
// Self-checking bench of the host port, parallel and serial, with a behavioural host.
`timescale 1ns/1ps
module mchi_host_port_bench import mchi_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic irq_n = 1'b1;
  logic [31:0] sts;
  logic [95:0] rrd;
  logic cs_n, wr_n, rd_n, sck, hen, miso, miso_oe_n, miso_w, hold_n, int_n, smode;
  logic [3:0] addr;
  logic [7:0] hd, dbus, dout, doe_n, rdv;
  logic [5:0] sp;
  logic [5:0] sp_val = 6'h15;
  logic [5:0] sp_drv = 6'h03;
  logic cmd_valid, regw_valid, hold_seen;
  logic [1:0] cmd_axis, regw_axis;
  logic [7:0] cmd_byte;
  logic [23:0] regw_data;
  logic [9:0] last_cmd;
  logic [25:0] last_regw;
  logic [39:0] rx;
  int error_cnt = 0;
  int total_checks = 0;
  int cmd_cnt = 0;
  int regw_cnt = 0;

  always #50 clk = ~clk;

  // Axis n reports status 11h*(n+1) and a readable register of {C0h+n, B0h+n, A0h+n}.
  initial begin
    for (int n = 0; n < 4; n++) begin
      sts[n*8 +: 8] = 8'h11 * (n + 1);
      rrd[n*24 +: 24] = {8'hC0 + n[7:0], 8'hB0 + n[7:0], 8'hA0 + n[7:0]};
    end
  end

  // A released data pin shows the inverse of the host's last value; MISO has a pull-up.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dbus[i] = (doe_n[i] === 1'b0) ? dout[i] : (hen ? hd[i] : ~hd[i]);
    end
  end
  assign miso_w = (miso_oe_n === 1'b0) ? miso : 1'b1;

  // Commit pulses are counted and wait requests flagged here so the scenarios can judge them later.
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      cmd_cnt++;
      last_cmd = {cmd_axis, cmd_byte};
    end
    if (regw_valid === 1'b1) begin
      regw_cnt++;
      last_regw = {regw_axis, regw_data};
    end
    if (hold_n === 1'b0) begin
      hold_seen = 1'b1;
    end
  end

  mchi_host_model i_mchi_host_model (.sys_clk_in(clk), .miso_in(miso_w), .bus_in(dbus), .cs_n_out(cs_n),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .sck_out(sck), .addr_out(addr), .data_out(hd), .drive_out(hen));

  mchi_host_port #(.NUM_AXES(4)) i_mchi_host_port (.sys_clk_in(clk), .srst_in(srst), .spi_sck_in(sck),
    .cs_ss_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n), .addr_lines_in(addr), .host_data_bus_in(dbus),
    .host_data_bus_out(dout), .host_data_bus_oe_n_out(doe_n), .hold_request_n_out(hold_n), .miso_out(miso),
    .miso_oe_n_out(miso_oe_n), .int_n_out(int_n), .serial_mode_out(smode), .irq_n_in(irq_n),
    .main_status_in(sts), .reg_read_data_in(rrd), .sp_value_in(sp_val), .sp_drive_in(sp_drv),
    .shared_port_pins_out(sp), .cmd_valid_out(cmd_valid), .cmd_axis_out(cmd_axis), .cmd_byte_out(cmd_byte),
    .regw_valid_out(regw_valid), .regw_axis_out(regw_axis), .regw_data_out(regw_data));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Reset for 20 cycles with the strobes strapped for the wanted interface.
  task do_reset(input logic serial);
    @(negedge clk);
    srst = 1'b1;
    i_mchi_host_model.straps(serial);
    repeat (20) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
  endtask : do_reset

  // Command writes to every axis, each one landing on its own axis.
  task t_par_cmd;
    chk(smode, 1'b0);
    chk(doe_n, 8'hFF);
    for (int ax = 0; ax < 4; ax++) begin
      i_mchi_host_model.pwr({ax[1:0], LA_CMD}, 8'h30 + ax[7:0]);
      chk(cmd_cnt, ax + 1);
      chk(last_cmd, {ax[1:0], 8'h30 + ax[7:0]});
    end
  endtask : t_par_cmd

  // Upper bytes only store; the low byte commits all 24 bits and makes the next access wait.
  task t_par_reg;
    i_mchi_host_model.pwr({AX_Z, LA_UP}, 8'hC3);
    hold_seen = 1'b0;
    i_mchi_host_model.pwr({AX_Z, LA_MID}, 8'hB2);
    chk(regw_cnt, 0);
    chk(hold_seen, 1'b0);
    // A short gap puts the next write inside the processing time, so it must be held off.
    i_mchi_host_model.tail = 1;
    i_mchi_host_model.pwr({AX_Z, LA_LOW}, 8'hA1);
    i_mchi_host_model.tail = 5;
    i_mchi_host_model.pwr({AX_Z, LA_UP}, 8'hC3);
    chk(hold_seen, 1'b1);
    chk(regw_cnt, 1);
    chk(last_regw, {AX_Z, 24'hC3B2A1});
  endtask : t_par_reg

  // Status and all three read buffer bytes of every axis.
  task t_par_read;
    for (int ax = 0; ax < 4; ax++) begin
      i_mchi_host_model.prd({ax[1:0], LA_CMD}, rdv);
      chk(rdv, 8'h11 * (ax + 1));
      for (int la = 1; la < 4; la++) begin
        i_mchi_host_model.prd({ax[1:0], la[1:0]}, rdv);
        chk(rdv, 8'h90 + (la << 4) + ax);
      end
    end
  endtask : t_par_read

  // The interrupt output follows its source alike in either mode.
  task t_irq;
    irq_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(int_n, 1'b0);
    irq_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(int_n, 1'b1);
  endtask : t_irq

  // Serial mode: own unit id answered, other id ignored, register frame read back on MISO.
  task t_serial;
    do_reset(1'b1);
    chk(smode, 1'b1);
    i_mchi_host_model.sframe(2, {8'h06, 8'h5A, 24'h0}, rx);
    chk(last_cmd, {2'h1, 8'h5A});
    i_mchi_host_model.sframe(2, {8'h05, 8'h66, 24'h0}, rx);
    chk(cmd_cnt, 5);
    chk(rx[15:0], 16'hFFFF);
    i_mchi_host_model.sframe(5, {8'h0E, 8'h77, 24'hA55BC6}, rx);
    chk(last_regw, {2'h3, 24'hC65BA5});
    chk(last_cmd, {2'h3, 8'h77});
    chk(rx[23:0], 24'hA3B3C3);
    chk(sp, 6'h29);
    chk(doe_n, 8'hFC);
    t_irq();
  endtask : t_serial

  // Main sequence.
  initial begin
    do_reset(1'b0);
    t_par_cmd();
    t_par_reg();
    t_par_read();
    t_irq();
    t_serial();
    conclude();
  end

  // Watchdog: the whole run needs well under 2000 cycles.
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end
endmodule : mchi_host_port_bench
